//--- rtl/ebmf_pkg.sv
// Package of constants and types for the block memory FIFO with write modes.
package ebmf_pkg;
  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int EBMF_ADDR_W = 9;
  localparam int EBMF_DATA_W = 18;
  localparam int EBMF_DEPTH = 512;
  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [EBMF_DATA_W-1:0] EBMF_DOUT_RST = 18'h0_0000;
  localparam logic [EBMF_ADDR_W:0] EBMF_PTR_RST = 10'h000;
  localparam logic [EBMF_ADDR_W:0] EBMF_EMPTY_LEVEL = 10'h000;
  localparam logic EBMF_EMPTY_RST = 1'b1;
  localparam logic EBMF_AEMPTY_RST = 1'b1;
  localparam logic EBMF_FULL_RST = 1'b0;
  localparam logic EBMF_AFULL_RST = 1'b0;
  // ----------------------------------------------------------------------
  // Write-behaviour modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    EBMF_WM_NORMAL = 2'b00,
    EBMF_WM_THROUGH = 2'b01,
    EBMF_WM_RBW = 2'b10
  } ebmf_wmode_t;
endpackage

//--- rtl/ebmf_port_if.sv
// Interface carrying one memory port's request and read data.
`timescale 1ns/1ps
interface ebmf_port_if #(parameter int AW = 9, parameter int DW = 18);
  logic en;
  logic we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  logic rd_valid;
  modport ctrl (output en, output we, output addr, output wdata, input rdata, input rd_valid);
  modport mem (input en, input we, input addr, input wdata, output rdata, output rd_valid);
endinterface

//--- rtl/ebmf_port.sv
// One memory port: write-mode selection and the resettable output latch.
`timescale 1ns/1ps
module ebmf_port
  import ebmf_pkg::*;
#(
  parameter int DW = 18
) (
  // Clock and resets.
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic local_rst_i,
  // Port request and memory data.
  ebmf_port_if.mem port,
  input wire logic [DW-1:0] mem_word_i,
  input wire ebmf_wmode_t wmode_i,
  // Latched output.
  output logic [DW-1:0] dout_o
);
  // ----------------------------------------------------------------------
  // Output selection
  // ----------------------------------------------------------------------
  // Read-before-write only exists at 9, 18 and 36 bits; other widths fall back to normal.
  wire rbw_ok = (DW == 9) || (DW == 18) || (DW == 36);
  wire do_rd = port.en && !port.we;
  wire do_wr = port.en && port.we;
  wire upd_thr = do_wr && (wmode_i == EBMF_WM_THROUGH);
  wire upd_rbw = do_wr && (wmode_i == EBMF_WM_RBW) && rbw_ok;
  wire load = do_rd || upd_thr || upd_rbw;
  wire [DW-1:0] next_dout = upd_thr ? port.wdata : mem_word_i;

  // Latch clears asynchronously from its local reset or the chip-wide reset.
  always_ff @(posedge clock_i or posedge sys_rst_i or posedge local_rst_i) begin
    if (sys_rst_i || local_rst_i) begin
      dout_o <= EBMF_DOUT_RST;
    end else if (load) begin
      dout_o <= next_dout; // Normal writes leave the latch untouched.
    end
  end
  assign port.rdata = dout_o;
  assign port.rd_valid = load;
endmodule

//--- rtl/ebmf_top.sv
// Block memory usable as dual-port RAM or as FIFO with programmable flags.
//
// Functional notes
// - Normal mode: output shows stored data only on reads, not writes.
// - Write-through: output of writing port shows the written word.
// - Read-before-write: old contents shown; only 9, 18, 36 bit widths.
// - All write modes available for single and dual port use.
// - FIFO makes full, almost full, almost empty and empty flags.
// - Full and almost full are registered on the write clock.
// - Empty and almost empty are registered on the read clock.
// - Full threshold programmable from one to two to the N minus one.
// - N is the FIFO address width.
// - Almost thresholds lift zero to one and are not capped at full minus one; empty fixed at zero.
// - FIFO global reset clears both pointers and returns flags to reset.
// - Retransmit reset moves only the read pointer back.
// - Output latches of both ports reset asynchronously.
// - In dual-port RAM mode each local reset clears only its own port's output latch.
// - Chip-wide reset clears both ports' output latches.
`timescale 1ns/1ps
module ebmf_top
  import ebmf_pkg::*;
#(
  parameter int AW = EBMF_ADDR_W,
  parameter int DW = EBMF_DATA_W
) (
  // Clock and chip-wide reset.
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic chip_wide_reset_n_i,
  // Configuration.
  input wire logic fifo_mode_i,
  input wire ebmf_wmode_t wmode_a_i,
  input wire ebmf_wmode_t wmode_b_i,
  input wire logic [AW:0] full_thresh_i,
  input wire logic [AW:0] afull_thresh_i,
  input wire logic [AW:0] aempty_thresh_i,
  // Port A, or the FIFO write port.
  input wire logic port_a_or_fifo_global_reset_i,
  input wire logic write_clock_enable_i,
  input wire logic we_a_i,
  input wire logic [AW-1:0] addr_a_i,
  input wire logic [DW-1:0] din_a_i,
  output logic [DW-1:0] dout_a_o,
  // Port B, or the FIFO read port.
  input wire logic port_b_or_read_pointer_reset_i,
  input wire logic read_clock_enable_i,
  input wire logic re_b_i,
  input wire logic we_b_i,
  input wire logic [AW-1:0] addr_b_i,
  input wire logic [DW-1:0] din_b_i,
  output logic [DW-1:0] dout_b_o,
  // FIFO flags.
  output logic full_flag_o,
  output logic almost_full_flag_o,
  output logic almost_empty_flag_o,
  output logic empty_flag_o
);
  // ----------------------------------------------------------------------
  // Storage and FIFO pointers
  // ----------------------------------------------------------------------
  logic [DW-1:0] mem [2**AW];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire chip_rst = sys_rst_i || !chip_wide_reset_n_i;
  // Both ports share clock_i, so the write and read domains coincide here.
  wire fifo_rst = fifo_mode_i && port_a_or_fifo_global_reset_i;
  wire retx_rst = fifo_mode_i && port_b_or_read_pointer_reset_i;
  wire fifo_wr = fifo_mode_i && write_clock_enable_i && we_a_i && !full_flag_o;
  wire fifo_rd = fifo_mode_i && read_clock_enable_i && re_b_i && !empty_flag_o;
  wire [AW:0] next_wr_ptr = fifo_wr ? wr_ptr + 1'b1 : wr_ptr;
  wire [AW:0] next_rd_ptr = retx_rst ? EBMF_PTR_RST : (fifo_rd ? rd_ptr + 1'b1 : rd_ptr);
  wire [AW:0] next_count = next_wr_ptr - next_rd_ptr;

  // Threshold clamps lift zero thresholds to one; only the full threshold is also capped, at FULL_MAX.
  localparam logic [AW:0] FULL_MAX = (AW+1)'((2**AW) - 1);
  localparam logic [AW:0] ONE = (AW+1)'(1);
  wire [AW:0] full_lvl = (full_thresh_i == '0) ? ONE :
                         (full_thresh_i > FULL_MAX ? FULL_MAX : full_thresh_i);
  wire [AW:0] afull_lvl = (afull_thresh_i == '0) ? ONE : afull_thresh_i;
  wire [AW:0] aempty_lvl = (aempty_thresh_i == '0) ? ONE : aempty_thresh_i;

  // Pointers; a global FIFO reset clears both, retransmit only the read side.
  always_ff @(posedge clock_i or posedge chip_rst) begin
    if (chip_rst) begin
      wr_ptr <= EBMF_PTR_RST;
      rd_ptr <= EBMF_PTR_RST;
    end else if (fifo_rst) begin
      wr_ptr <= EBMF_PTR_RST;
      rd_ptr <= EBMF_PTR_RST;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // ----------------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------------
  // Write-side flags, registered on the write clock.
  always_ff @(posedge clock_i or posedge chip_rst) begin
    if (chip_rst) begin
      full_flag_o <= EBMF_FULL_RST;
      almost_full_flag_o <= EBMF_AFULL_RST;
    end else if (fifo_rst) begin
      full_flag_o <= EBMF_FULL_RST;
      almost_full_flag_o <= EBMF_AFULL_RST;
    end else begin
      full_flag_o <= (next_count >= full_lvl);
      almost_full_flag_o <= (next_count >= afull_lvl);
    end
  end

  // Read-side flags, registered on the read clock; empty means zero entries.
  always_ff @(posedge clock_i or posedge chip_rst) begin
    if (chip_rst) begin
      empty_flag_o <= EBMF_EMPTY_RST;
      almost_empty_flag_o <= EBMF_AEMPTY_RST;
    end else if (fifo_rst) begin
      empty_flag_o <= EBMF_EMPTY_RST;
      almost_empty_flag_o <= EBMF_AEMPTY_RST;
    end else begin
      empty_flag_o <= (next_count == EBMF_EMPTY_LEVEL);
      almost_empty_flag_o <= (next_count <= aempty_lvl);
    end
  end

  // ----------------------------------------------------------------------
  // Port requests
  // ----------------------------------------------------------------------
  ebmf_port_if #(.AW(AW), .DW(DW)) pa ();
  ebmf_port_if #(.AW(AW), .DW(DW)) pb ();
  // In FIFO mode port A is the write side and port B the read side.
  assign pa.en = fifo_mode_i ? fifo_wr : write_clock_enable_i;
  assign pa.we = fifo_mode_i ? 1'b1 : we_a_i;
  assign pa.addr = fifo_mode_i ? wr_ptr[AW-1:0] : addr_a_i;
  assign pa.wdata = din_a_i;
  assign pb.en = fifo_mode_i ? fifo_rd : read_clock_enable_i;
  assign pb.we = fifo_mode_i ? 1'b0 : we_b_i;
  assign pb.addr = fifo_mode_i ? rd_ptr[AW-1:0] : addr_b_i;
  assign pb.wdata = din_b_i;

  // Array writes; port B wins a same-address collision as a documented limitation.
  always_ff @(posedge clock_i) begin
    if (pa.en && pa.we) begin
      mem[pa.addr] <= pa.wdata;
    end
    if (pb.en && pb.we) begin
      mem[pb.addr] <= pb.wdata;
    end
  end

  // In FIFO mode the local resets drive the pointers, not the latches.
  wire lrst_a = !fifo_mode_i && port_a_or_fifo_global_reset_i;
  wire lrst_b = !fifo_mode_i && port_b_or_read_pointer_reset_i;

  // ----------------------------------------------------------------------
  // Output ports
  // ----------------------------------------------------------------------
  ebmf_port #(.DW(DW)) u_port_a (
    .clock_i(clock_i),
    .sys_rst_i(chip_rst),
    .local_rst_i(lrst_a),
    .port(pa),
    .mem_word_i(mem[pa.addr]),
    .wmode_i(wmode_a_i),
    .dout_o(dout_a_o)
  );
  ebmf_port #(.DW(DW)) u_port_b (
    .clock_i(clock_i),
    .sys_rst_i(chip_rst),
    .local_rst_i(lrst_b),
    .port(pb),
    .mem_word_i(mem[pb.addr]),
    .wmode_i(fifo_mode_i ? EBMF_WM_NORMAL : wmode_b_i),
    .dout_o(dout_b_o)
  );
endmodule

//--- sim/ebmf_checker.sv
// Port-level assertions for the block memory FIFO with write modes.
`timescale 1ns/1ps
module ebmf_checker
  import ebmf_pkg::*;
#(parameter int AW = 9, parameter int DW = 18) (
  // Clock and resets.
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic chip_wide_reset_n_i,
  // Configuration.
  input wire logic fifo_mode_i,
  input wire ebmf_wmode_t wmode_a_i,
  input wire ebmf_wmode_t wmode_b_i,
  input wire logic [AW:0] full_thresh_i,
  input wire logic [AW:0] afull_thresh_i,
  input wire logic [AW:0] aempty_thresh_i,
  // Port A.
  input wire logic port_a_or_fifo_global_reset_i,
  input wire logic write_clock_enable_i,
  input wire logic we_a_i,
  input wire logic [AW-1:0] addr_a_i,
  input wire logic [DW-1:0] din_a_i,
  input wire logic [DW-1:0] dout_a_o,
  // Port B.
  input wire logic port_b_or_read_pointer_reset_i,
  input wire logic read_clock_enable_i,
  input wire logic re_b_i,
  input wire logic we_b_i,
  input wire logic [AW-1:0] addr_b_i,
  input wire logic [DW-1:0] din_b_i,
  input wire logic [DW-1:0] dout_b_o,
  // Flags.
  input wire logic full_flag_o,
  input wire logic almost_full_flag_o,
  input wire logic almost_empty_flag_o,
  input wire logic empty_flag_o
);
  // Request decodes; only wa folds in its reset, the refusal checks exclude the resets so a clear never reads as a refusal.
  wire wr = fifo_mode_i & write_clock_enable_i & we_a_i;
  wire rd = fifo_mode_i & read_clock_enable_i & re_b_i;
  wire ra = port_a_or_fifo_global_reset_i;
  wire rb = port_b_or_read_pointer_reset_i;
  wire wa = !fifo_mode_i & write_clock_enable_i & we_a_i & !ra;
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i || !chip_wide_reset_n_i);
  // A retransmit reset may legally drop the count, so it is left out of the hold check.
  chk_full_refuse: assert property (fifo_mode_i && full_flag_o && !rd && !ra && !rb
    |=> full_flag_o) else $error("full flag dropped without a read");
  chk_empty_refuse: assert property (rd && empty_flag_o && !wr && !ra && !rb
    |=> empty_flag_o && $stable(dout_b_o)) else $error("read taken while empty");
  chk_empty_aempty: assert property (fifo_mode_i && empty_flag_o
    |-> almost_empty_flag_o) else $error("empty without almost empty");
  chk_full_afull: assert property (fifo_mode_i && full_flag_o
    && afull_thresh_i < full_thresh_i |-> almost_full_flag_o) else $error("full w/o afull");
  chk_flag_excl: assert property (fifo_mode_i |-> !(empty_flag_o && full_flag_o))
    else $error("empty and full together");
  chk_global_clear: assert property (fifo_mode_i && ra |=> empty_flag_o
    && almost_empty_flag_o && !full_flag_o && !almost_full_flag_o) else $error("no clear");
  chk_write_fill: assert property (wr && !full_flag_o && !rd && !ra && !rb
    |=> !empty_flag_o) else $error("write left the FIFO empty");
  chk_write_through: assert property (wa && wmode_a_i == EBMF_WM_THROUGH
    |=> ra || dout_a_o == $past(din_a_i)) else $error("written word not shown");
  chk_normal_hold: assert property (wa && wmode_a_i == EBMF_WM_NORMAL
    |=> ra || $stable(dout_a_o)) else $error("normal write changed output");
  chk_local_clear: assert property (!fifo_mode_i && ra |-> dout_a_o == '0)
    else $error("port A latch not cleared");
  chk_chip_clear: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !chip_wide_reset_n_i |-> dout_a_o == '0 && dout_b_o == '0) else $error("latch kept");
endmodule
bind ebmf_top ebmf_checker #(.AW(AW), .DW(DW)) u_chk (.*);

//--- sim/ebmf_user.sv
// Fabric-side user logic model driving port A, which is also the FIFO write port.
`timescale 1ns/1ps
module ebmf_user
  import ebmf_pkg::*;
(
  // Clock.
  input wire logic clock_i,
  // Port A request.
  output logic write_clock_enable_o,
  output logic we_o,
  output logic [EBMF_ADDR_W-1:0] addr_o,
  output logic [EBMF_DATA_W-1:0] din_o
);
  // Idle from time zero, so no request is seen during reset.
  initial begin
    {write_clock_enable_o, we_o, addr_o, din_o} = '0;
  end
  // One request held over one taking edge; data is inverted after it so stale data never matches.
  task automatic access(input logic w, input logic [EBMF_ADDR_W-1:0] a,
    input logic [EBMF_DATA_W-1:0] d);
    @(negedge clock_i);
    {write_clock_enable_o, we_o, addr_o, din_o} = {1'b1, w, a, d};
    @(negedge clock_i);
    {write_clock_enable_o, we_o, din_o} = {2'b00, ~d};
  endtask
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the block memory FIFO with write modes.
`timescale 1ns/1ps
module tb_top;
  import ebmf_pkg::*;
  // Bench signals carry the port names of the block so it connects by name.
  logic clock_i = 0, sys_rst_i = 1, chip_wide_reset_n_i = 1, fifo_mode_i = 0;
  logic port_a_or_fifo_global_reset_i = 0, port_b_or_read_pointer_reset_i = 0;
  logic read_clock_enable_i = 0, re_b_i = 0, we_b_i = 0, write_clock_enable_i, we_a_i;
  logic [8:0] addr_b_i = 0, addr_a_i;
  logic [17:0] din_b_i = 0, din_a_i, dout_a_o, dout_b_o;
  logic [9:0] full_thresh_i = 10'h004, afull_thresh_i = 10'h003, aempty_thresh_i = 10'h001;
  ebmf_wmode_t wmode_a_i = EBMF_WM_NORMAL, wmode_b_i = EBMF_WM_RBW;
  logic full_flag_o, almost_full_flag_o, almost_empty_flag_o, empty_flag_o;
  localparam logic [17:0] hi = 18'h0_0001, lo = 18'h0_0000;
  int miscompares = 0, cmp_count = 0;
  always #25 clock_i = ~clock_i;
  ebmf_user u_user (.clock_i(clock_i), .write_clock_enable_o(write_clock_enable_i),
    .we_o(we_a_i), .addr_o(addr_a_i), .din_o(din_a_i));
  ebmf_top u_dut (.*);
  task chk(input logic [17:0] seen, input logic [17:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    if (miscompares == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Port B request, held over one taking edge like the port A model.
  task bacc(input logic r, input logic w, input logic [8:0] a, input logic [17:0] d);
    @(negedge clock_i);
    {read_clock_enable_i, re_b_i, we_b_i, addr_b_i, din_b_i} = {1'b1, r, w, a, d};
    @(negedge clock_i);
    {read_clock_enable_i, re_b_i, we_b_i, din_b_i} = {3'b000, ~d};
  endtask
  // A hang costs no more than this span; the tests take about fifty cycles.
  initial begin
    #20us;
    miscompares++;
    finish_test;
  end
  initial begin
    repeat (6) @(negedge clock_i);
    sys_rst_i = 0;
    chk(dout_a_o, lo);
    chk(empty_flag_o, hi);
    u_user.access(1, 5, 18'h1_2345);
    chk(dout_a_o, lo);
    u_user.access(0, 5, lo);
    chk(dout_a_o, 18'h1_2345);
    wmode_a_i = EBMF_WM_THROUGH;
    u_user.access(1, 6, 18'h0_0abc);
    chk(dout_a_o, 18'h0_0abc);
    bacc(0, 1, 6, 18'h3_3333);
    chk(dout_b_o, 18'h0_0abc);
    bacc(0, 0, 6, lo);
    chk(dout_b_o, 18'h3_3333);
    // Port A in read-before-write shows the word that port B stored at address 6.
    wmode_a_i = EBMF_WM_RBW;
    u_user.access(1, 6, 18'h0_5555);
    chk(dout_a_o, 18'h3_3333);
    // Port B in write-through shows its own written word.
    wmode_b_i = EBMF_WM_THROUGH;
    bacc(0, 1, 7, 18'h0_0777);
    chk(dout_b_o, 18'h0_0777);
    port_a_or_fifo_global_reset_i = 1;
    #1 chk(dout_a_o, lo);
    chk(dout_b_o, 18'h0_0777);
    chip_wide_reset_n_i = 0;
    #1 chk(dout_b_o, lo);
    @(negedge clock_i);
    {port_a_or_fifo_global_reset_i, chip_wide_reset_n_i, sys_rst_i, fifo_mode_i} = 4'b0111;
    @(negedge clock_i);
    sys_rst_i = 0;
    // Five writes into a FIFO that fills at four; the fifth must be dropped.
    for (int i = 0; i < 5; i++) u_user.access(1, 0, 18'h0_0100 + 18'(i));
    chk(full_flag_o, hi);
    chk(almost_full_flag_o, hi);
    chk(almost_empty_flag_o, lo);
    for (int i = 0; i < 4; i++) begin
      bacc(1, 0, 0, lo);
      chk(dout_b_o, 18'h0_0100 + 18'(i));
    end
    chk(empty_flag_o, hi);
    bacc(1, 0, 0, lo);
    chk(dout_b_o, 18'h0_0103);
    // All four words are known to be held, so replaying them is safe.
    port_b_or_read_pointer_reset_i = 1;
    @(negedge clock_i);
    port_b_or_read_pointer_reset_i = 0;
    chk(empty_flag_o, lo);
    bacc(1, 0, 0, lo);
    chk(dout_b_o, 18'h0_0100);
    port_a_or_fifo_global_reset_i = 1;
    @(negedge clock_i);
    port_a_or_fifo_global_reset_i = 0;
    chk(empty_flag_o, hi);
    chk(almost_empty_flag_o, hi);
    finish_test;
  end
endmodule
